//--- hw/sbc_detect.sv
// link-clock start, stop and bit detector
`timescale 1ns/1ps
module sbc_detect
  import sbc_pkg::*;
(
  input wire logic link_clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  sbc_evt_if.det evt
);
  logic rst_s1_q, rst_s2_q;
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic start_q, start_d, stop_q, stop_d, bit_q, bit_d, val_q, val_d;
  logic is_start, is_stop, is_bit;

  // reset passes two stages and pins pass three; stage one feeds only stage two
  always_ff @(posedge link_clk) begin
    rst_s1_q <= rst;
    rst_s2_q <= rst_s1_q;
    scl_s1_q <= scl_i;
    scl_s2_q <= scl_s1_q;
    scl_s3_q <= scl_s2_q;
    sda_s1_q <= sda_i;
    sda_s2_q <= sda_s1_q;
    sda_s3_q <= sda_s2_q;
  end

  // compare successive samples
  // data edge with clock high on both samples is framing only
  assign is_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign is_stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
  // bit taken on clock rise; master keeps data steady while high
  assign is_bit = scl_s2_q & ~scl_s3_q;

  // each event flips a toggle so the other domain sees it once
  always_comb begin
    start_d = start_q ^ is_start;
    stop_d = stop_q ^ is_stop;
    bit_d = bit_q ^ is_bit;
    val_d = is_bit ? sda_s2_q : val_q;
  end

  always_ff @(posedge link_clk) begin
    if (rst_s2_q) begin
      start_q <= 1'h0;
      stop_q <= 1'h0;
      bit_q <= 1'h0;
      val_q <= 1'h0;
    end else begin
      start_q <= start_d;
      stop_q <= stop_d;
      bit_q <= bit_d;
      val_q <= val_d;
    end
  end

  assign evt.start_tgl = start_q;
  assign evt.stop_tgl = stop_q;
  assign evt.bit_tgl = bit_q;
  assign evt.bit_val = val_q; // held from one bit to the next, stable when toggle lands
endmodule : sbc_detect

//--- hw/sbc_evt_if.sv
// events passed from the link-clock detector to the system-clock side
`timescale 1ns/1ps
interface sbc_evt_if;
  logic start_tgl;
  logic stop_tgl;
  logic bit_tgl;
  logic bit_val;
  modport det (output start_tgl, output stop_tgl, output bit_tgl, output bit_val);
  modport core (input start_tgl, input stop_tgl, input bit_tgl, input bit_val);
endinterface : sbc_evt_if

//--- hw/sbc_pkg.sv
// constants and types for the serial memory bus-condition block
package sbc_pkg;
  // system clock rate in kHz
  localparam int unsigned SYS_CLK_KHZ = 10000;
  // power_init_wait, least time, in microseconds
  localparam int unsigned POWER_INIT_WAIT_US = 100;
  // least time rounds up to whole cycles
  localparam int unsigned POWER_INIT_CYCLES = (POWER_INIT_WAIT_US * SYS_CLK_KHZ + 999) / 1000;
  // internal_write_duration, longest time, in milliseconds
  localparam int unsigned INT_WRITE_MS = 5;
  // longest time rounds down
  localparam int unsigned INT_WRITE_CYCLES = INT_WRITE_MS * SYS_CLK_KHZ;
  // counter width covers both timers
  localparam int unsigned TMR_W = 20;
  // reset values
  localparam logic [TMR_W-1:0] TMR_RST = 20'h00000;
  localparam logic SYNC_RST = 1'h1;

  // device operating state, one-hot
  typedef enum logic [3:0] {
    ST_INIT = 4'h1,
    ST_STANDBY = 4'h2,
    ST_ACTIVE = 4'h4,
    ST_WRITE = 4'h8
  } sbc_state_t;
endpackage : sbc_pkg

//--- hw/sbc_top.sv
// bus-condition, power-up and write-cycle timing core of the serial memory
`timescale 1ns/1ps
module sbc_top
  import sbc_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = INT_WRITE_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic sda_pull_low,
  input wire logic write_pending,
  output logic bus_ready,
  output logic standby,
  output logic in_transaction,
  output logic write_busy,
  output logic start_pulse,
  output logic stop_pulse,
  output logic bit_valid,
  output logic bit_data,
  output logic write_done
);
  sbc_evt_if evt ();

  sbc_detect u_detect (
    .link_clk(link_clk),
    .rst(rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .evt(evt)
  );

  // toggles cross with two stages; third stage only for edge compare
  logic [2:0] st_sync_q, sp_sync_q, bt_sync_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_sync_q <= 3'h0;
      sp_sync_q <= 3'h0;
      bt_sync_q <= 3'h0;
    end else begin
      st_sync_q <= {st_sync_q[1:0], evt.start_tgl};
      sp_sync_q <= {sp_sync_q[1:0], evt.stop_tgl};
      bt_sync_q <= {bt_sync_q[1:0], evt.bit_tgl};
    end
  end

  logic got_start, got_stop, got_bit;
  assign got_start = st_sync_q[2] ^ st_sync_q[1];
  assign got_stop = sp_sync_q[2] ^ sp_sync_q[1];
  assign got_bit = bt_sync_q[2] ^ bt_sync_q[1];

  sbc_state_t state_q, state_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic start_q, start_d, stop_q, stop_d, bv_q, bv_d, bd_q, bd_d, wd_q, wd_d;

  // operating state and its timer
  always_comb begin
    state_d = state_q;
    tmr_d = tmr_q;
    start_d = 1'h0;
    stop_d = 1'h0;
    bv_d = 1'h0;
    bd_d = bd_q;
    wd_d = 1'h0;
    case (state_q)
      ST_INIT: begin
        // bus events are dropped while initialising
        if (tmr_q == TMR_W'(POWER_INIT_CYCLES - 1)) begin
          state_d = ST_STANDBY;
          tmr_d = TMR_RST;
        end else begin
          tmr_d = tmr_q + TMR_W'(1);
        end
      end
      ST_STANDBY: begin
        // bits and stops before a start are ignored
        if (got_start) begin
          state_d = ST_ACTIVE;
          start_d = 1'h1;
        end
      end
      ST_ACTIVE: begin
        if (got_stop) begin
          stop_d = 1'h1;
          // write sequence: timed cycle begins at this stop
          if (write_pending) begin
            state_d = ST_WRITE;
            tmr_d = TMR_RST;
          end else begin
            state_d = ST_STANDBY;
          end
        end else if (got_start) begin
          start_d = 1'h1; // repeated start reframes the transaction
        end else if (got_bit) begin
          bv_d = 1'h1;
          bd_d = evt.bit_val;
        end
      end
      ST_WRITE: begin
        // inputs disabled; count ends at most five ms after the stop
        if (tmr_q == TMR_W'(WRITE_CYCLES - 1)) begin
          state_d = ST_STANDBY;
          tmr_d = TMR_RST;
          wd_d = 1'h1;
        end else begin
          tmr_d = tmr_q + TMR_W'(1);
        end
      end
      default: begin
        state_d = ST_INIT;
        tmr_d = TMR_RST;
      end
    endcase
  end

  // power-on reset starts the initialisation wait
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_INIT;
      tmr_q <= TMR_RST;
      start_q <= 1'h0;
      stop_q <= 1'h0;
      bv_q <= 1'h0;
      bd_q <= 1'h0;
      wd_q <= 1'h0;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      start_q <= start_d;
      stop_q <= stop_d;
      bv_q <= bv_d;
      bd_q <= bd_d;
      wd_q <= wd_d;
    end
  end

  // status levels straight from the state register
  assign bus_ready = (state_q == ST_STANDBY) | (state_q == ST_ACTIVE);
  assign standby = (state_q == ST_STANDBY);
  assign in_transaction = (state_q == ST_ACTIVE);
  assign write_busy = (state_q == ST_WRITE);
  assign start_pulse = start_q;
  assign stop_pulse = stop_q;
  assign bit_valid = bv_q;
  assign bit_data = bd_q;
  assign write_done = wd_q;

  // open-drain: only ever pulls low, and never outside a transaction
  assign sda_o = 1'h0;
  assign sda_oe = sda_pull_low & (state_q == ST_ACTIVE);
endmodule : sbc_top

//--- sim/sbc_master_model.sv
// behavioural two-wire bus master; phases are long so every event crosses
`timescale 1ns/1ps
module sbc_master_model (
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  task automatic ph;
    #600;
  endtask : ph
  // data falls while the clock is high, then the clock drops
  task automatic start;
    sda_low = 1'h0; ph(); scl = 1'h1; ph(); sda_low = 1'h1; ph(); scl = 1'h0; ph();
  endtask : start
  // data set only while the clock is low
  task automatic put(input logic b);
    sda_low = !b; ph(); scl = 1'h1; ph(); scl = 1'h0; ph();
  endtask : put
  task automatic stop;
    sda_low = 1'h1; ph(); scl = 1'h1; ph(); sda_low = 1'h0; ph();
  endtask : stop
endmodule : sbc_master_model

//--- sim/sbc_top_assertions.sv
// checker for the bus-condition core, bound to its ports
`timescale 1ns/1ps
module sbc_top_assertions
  import sbc_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = INT_WRITE_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sda_pull_low,
  input logic sda_oe,
  input logic bus_ready,
  input logic standby,
  input logic in_transaction,
  input logic write_busy,
  input logic start_pulse,
  input logic stop_pulse,
  input logic bit_valid
);
  logic [9:0] ic_q;
  logic [19:0] wc_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // cycles since reset and since the write began; the reset count saturates so it never wraps back into the quiet window
  always_ff @(posedge sys_clk) begin
    ic_q <= rst ? 10'h000 : ic_q + 10'(ic_q != 10'h3FF);
    wc_q <= (rst || !write_busy) ? 20'h00000 : wc_q + 20'h00001;
  end
  sequence wr_begin;
    stop_pulse ##0 write_busy;
  endsequence
  init_quiet_a: assert property (ic_q < 10'h3E0 |-> !bus_ready && !start_pulse) else $error("bus live in init");
  ready_standby_a: assert property ($rose(bus_ready) |-> standby) else $error("ready without standby");
  start_enter_a: assert property (start_pulse |-> in_transaction && !standby) else $error("start not taken");
  stop_end_a: assert property (stop_pulse |-> $past(in_transaction) && !in_transaction) else $error("bad stop");
  read_stop_a: assert property (stop_pulse && !write_busy |-> standby) else $error("no standby after read");
  bit_only_a: assert property (bit_valid |-> $past(in_transaction) && !start_pulse && !stop_pulse) else $error("bad bit");
  wr_hold_a: assert property (wr_begin |=> write_busy[*8]) else $error("write cycle cut short");
  wr_len_a: assert property (write_busy |-> wc_q <= WRITE_CYCLES) else $error("write cycle too long");
  wr_quiet_a: assert property (write_busy |-> !bus_ready && !start_pulse && !sda_oe) else $error("bus live in write");
  drive_gate_a: assert property (sda_oe |-> sda_pull_low && in_transaction) else $error("data driven outside");
endmodule : sbc_top_assertions
bind sbc_top sbc_top_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (.*);

//--- sim/tb.sv
// self-checking bench for the bus-condition core
`timescale 1ns/1ps
module tb;
  logic sys_clk = 0, link_clk = 0, rst = 1, sda_pull_low = 0, write_pending = 0, scl_i, m_low;
  logic sda_o, sda_oe, bus_ready, standby, in_transaction, write_busy;
  logic start_pulse, stop_pulse, bit_valid, bit_data, write_done;
  logic [7:0] bits = 8'h00;
  int n_errors = 0, n_compared = 0, n_st = 0, n_sp = 0, n_wd = 0;
  // pull-up wins unless master or device pulls low
  wire sda_i = !(m_low || sda_oe);
  initial forever #50 sys_clk = ~sys_clk;
  // link clock starts off the system grid so the two never line up
  initial begin
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  sbc_top #(.WRITE_CYCLES(20)) dut_u (.*);
  sbc_master_model m_u (.scl(scl_i), .sda_low(m_low));
  // tally one-cycle pulses after they have settled
  always @(negedge sys_clk) begin
    if (start_pulse) n_st++;
    if (stop_pulse) n_sp++;
    if (bit_valid) bits = {bits[6:0], bit_data};
    if (write_done) n_wd++;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // bounded wait for standby; judged on the level itself so a late arrival is not a timeout
  task automatic wt_standby(input int lim);
    int i;
    for (i = 0; i < lim && standby !== 1'b1; i++) @(negedge sys_clk);
    if (standby !== 1'b1) begin
      chk("wait", 8'h01, 8'h00);
      end_sim();
    end
  endtask : wt_standby
  // a frame during power-up must leave no trace
  task automatic t_init;
    m_u.start();
    m_u.stop();
    chk("starts", 8'h00, 8'(n_st));
    chk("standby", 8'h00, 8'(standby));
    wt_standby(1100);
    chk("ready", 8'h01, 8'(bus_ready));
  endtask : t_init
  task automatic t_read;
    m_u.start();
    chk("in_transaction", 8'h01, 8'(in_transaction));
    m_u.put(1'h1);
    // master leaves the line released here, so only the device can pull it low
    sda_pull_low = 1'h1;
    #1 chk("sda", 8'h00, 8'(sda_i));
    chk("sda_oe", 8'h01, 8'(sda_oe));
    chk("sda_o", 8'h00, 8'(sda_o));
    @(negedge sys_clk);
    sda_pull_low = 1'h0;
    m_u.put(1'h0);
    // judged before the repeated start, whose clock rise is sampled as one more bit
    chk("bits", 8'h02, bits);
    // repeated start keeps the transaction open
    m_u.start();
    chk("starts", 8'h02, 8'(n_st));
    chk("in_transaction", 8'h01, 8'(in_transaction));
    m_u.stop();
    chk("stops", 8'h01, 8'(n_sp));
    chk("standby", 8'h01, 8'(standby));
  endtask : t_read
  // a start during the write cycle is refused
  task automatic t_write;
    write_pending = 1'h1;
    m_u.start();
    m_u.put(1'h1);
    m_u.stop();
    chk("write_busy", 8'h01, 8'(write_busy));
    write_pending = 1'h0;
    // pull request raised in the write cycle; sda_oe is judged after the start returns, once standby is back
    sda_pull_low = 1'h1;
    m_u.start();
    chk("starts", 8'h03, 8'(n_st));
    chk("sda_oe", 8'h00, 8'(sda_oe));
    sda_pull_low = 1'h0;
    m_u.stop();
    wt_standby(40);
    chk("stops", 8'h02, 8'(n_sp));
    chk("write_done", 8'h01, 8'(n_wd));
  endtask : t_write
  initial begin
    repeat (4) @(negedge sys_clk);
    rst = 1'h0;
    t_init();
    t_read();
    t_write();
    end_sim();
  end
endmodule : tb
